// ===== logic/timer_input_capture.sv
// Timer input capture top: counter, port A sharing, AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "timer_capture_consts.svh"
module timer_input_capture #(
  parameter int NCH = 4,
  parameter int CW  = 16
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Port A pins
  input  wire logic [7:0]  port_a_in,
  output logic [7:0]       port_a_out,
  output logic [7:0]       port_a_oe_n,
  // Compare levels for pins 7..3 from the compare logic
  input  wire logic [4:0]  compare_level,
  // Events out
  output logic             watchdog_tick,
  output logic             capture_irq
);

  timer_capture_pkg::pacc_t     pacc_q;
  timer_capture_pkg::wr_state_t wr_state_q;
  logic [CW-1:0]      count_q;
  logic [7:0]         edge_q, flag_q, enable_q, oc1_mask_q, connect_q, port_out_q;
  logic [NCH-1:0]     block_q, strobe;
  logic [CW-1:0]      cap_value [NCH];
  logic               count_tick, wrap;
  logic               aw_held_q, w_held_q;
  logic [7:0]         aw_addr_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  logic [1:0]         bresp_q, rresp_q;
  logic               rvalid_q;
  logic [31:0]        rdata_q;

  // Divider chain and watchdog tap
  timer_prescaler #(.CHAIN_W(`TC_WD_CHAIN_W)) u_prescaler (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .prescale_select (pacc_q.prescale_select),
    .count_tick      (count_tick),
    .watchdog_tick   (watchdog_tick)
  );

  // Free-running counter; nothing but reset can disturb it
  assign wrap = count_tick && (count_q == `TC_COUNT_MAX);
  always_ff @(posedge aclk) begin
    if (!aresetn)        count_q <= `TC_COUNT_RESET;
    else if (count_tick) count_q <= count_q + 1'b1;
  end

  // Pin ownership: compare 5 uses the shared pin only while not capturing
  logic [7:0] owned, pa_drive, pa_dir;
  logic       ch4_pin;
  assign owned    = {oc1_mask_q[7:3], 3'h0} |
                    {1'b0, connect_q[6:4], connect_q[3] && !pacc_q.ch4_capture_select, 3'h0};
  assign pa_dir   = {pacc_q.pa7_dir, 3'h7, pacc_q.pa3_direction_bit, 3'h0};
  assign pa_drive = {owned[7:3] & compare_level | ~owned[7:3] & port_out_q[7:3],
                     port_out_q[2:0]};
  assign port_a_out  = pa_drive;
  assign port_a_oe_n = ~(pa_dir | owned);
  // Driven shared pin feeds its own level back so software writes make edges
  assign ch4_pin = pacc_q.pa3_direction_bit ? pa_drive[`TC_PIN_SHARED]
                                            : port_a_in[`TC_PIN_SHARED];

  // Write channel decode
  logic        aw_hs, w_hs, wr_go, wr_byte0;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic        w_cap, w_mapped, w_ch4, w_ch4_lo;
  assign aw_hs    = awvalid && awready;
  assign w_hs     = wvalid && wready;
  assign wa       = aw_held_q ? aw_addr_q : awaddr;
  assign wd       = w_held_q ? w_data_q : wdata;
  assign wr_byte0 = w_held_q ? w_strb_q[0] : wstrb[0];
  assign wr_go    = (wr_state_q == timer_capture_pkg::WR_IDLE) &&
                    (aw_held_q || aw_hs) && (w_held_q || w_hs);
  assign w_cap    = (wa[7:5] == `TC_CAP_REGION) && (wa[1:0] == 2'h0);
  assign w_mapped = w_cap || (wa[7:5] == 3'h0 && wa[1:0] == 2'h0);
  assign w_ch4    = wr_go && wr_byte0 && w_cap && (wa[4:3] == 2'h3)
                    && !pacc_q.ch4_capture_select;
  assign w_ch4_lo = wa[2];
  assign awready  = (wr_state_q == timer_capture_pkg::WR_IDLE) && !aw_held_q;
  assign wready   = (wr_state_q == timer_capture_pkg::WR_IDLE) && !w_held_q;
  assign bvalid   = (wr_state_q == timer_capture_pkg::WR_RESP);
  assign bresp    = bresp_q;

  // Write channel state: hold whichever of address or data arrives first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= timer_capture_pkg::WR_IDLE;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      aw_addr_q  <= `TC_BYTE_RESET;
      w_data_q   <= '0;
      w_strb_q   <= '0;
      bresp_q    <= `TC_RESP_OKAY;
    end else begin
      case (wr_state_q)
        timer_capture_pkg::WR_IDLE: begin
          if (wr_go) begin
            wr_state_q <= timer_capture_pkg::WR_RESP;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            bresp_q    <= w_mapped ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
          end else begin
            if (aw_hs) begin
              aw_held_q <= 1'b1;
              aw_addr_q <= awaddr;
            end
            if (w_hs) begin
              w_held_q <= 1'b1;
              w_data_q <= wdata;
              w_strb_q <= wstrb;
            end
          end
        end
        timer_capture_pkg::WR_RESP: begin
          if (bready) wr_state_q <= timer_capture_pkg::WR_IDLE;
        end
        default: wr_state_q <= timer_capture_pkg::WR_IDLE;
      endcase
    end
  end

  // Register writes; only byte lane 0 carries data
  logic wr_ok;
  assign wr_ok = wr_go && wr_byte0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pacc_q     <= `TC_BYTE_RESET;
      edge_q     <= `TC_BYTE_RESET;
      enable_q   <= `TC_BYTE_RESET;
      oc1_mask_q <= `TC_BYTE_RESET;
      connect_q  <= `TC_BYTE_RESET;
      port_out_q <= `TC_BYTE_RESET;
    end else if (wr_ok) begin
      case (wa)
        `TC_ADDR_PACC:       pacc_q     <= wd[7:0];
        `TC_ADDR_EDGE:       edge_q     <= wd[7:0];
        `TC_ADDR_ENABLE:     enable_q   <= wd[7:0];
        `TC_ADDR_OC1_MASK:   oc1_mask_q <= {wd[7:3], 3'h0};
        `TC_ADDR_OC_CONNECT: connect_q  <= {1'b0, wd[6:3], 3'h0};
        // Owned bits keep their stored level
        `TC_ADDR_PORT_A:     port_out_q <= (port_out_q & owned) | (wd[7:0] & ~owned);
        default:             pacc_q     <= pacc_q;
      endcase
    end
  end

  // Flags: a capture or wrap in the clearing cycle wins over the clear
  logic [7:0] flag_set, flag_clr;
  assign flag_set = {wrap, 3'h0, strobe};
  assign flag_clr = (wr_ok && wa == `TC_ADDR_FLAG) ? wd[7:0] : `TC_BYTE_RESET;
  always_ff @(posedge aclk) begin
    if (!aresetn) flag_q <= `TC_BYTE_RESET;
    else          flag_q <= (flag_q & ~flag_clr) | flag_set;
  end
  assign capture_irq = |(flag_q & enable_q);

  // Capture channels all sample the same stable count
  logic [CW-1:0] ch4_wr_data;
  logic [NCH-1:0] ch_pin, ch_en;
  assign ch4_wr_data = w_ch4_lo ? {cap_value[NCH-1][CW-1:8], wd[7:0]}
                                : {wd[7:0], cap_value[NCH-1][7:0]};
  assign ch_pin = {ch4_pin, port_a_in[2:0]};
  assign ch_en  = {pacc_q.ch4_capture_select, 3'h7};
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    capture_channel #(.W(CW)) u_ch (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin      (ch_pin[i]),
      .edge_sel (edge_q[2*i+1 -: 2]),
      .enable   (ch_en[i]),
      .block    (block_q[i]),
      .count    (count_q),
      .wr_en    (w_ch4 && (i == NCH-1)),
      .wr_data  (ch4_wr_data),
      .value_q  (cap_value[i]),
      .strobe   (strobe[i])
    );
  end

  // Read decode
  logic        ar_hs, r_cap, r_mapped;
  logic [1:0]  r_ch;
  logic [15:0] r_capval;
  logic [31:0] r_mux;
  assign arready  = !rvalid_q;
  assign ar_hs    = arvalid && arready;
  assign r_ch     = araddr[4:3];
  assign r_cap    = (araddr[7:5] == `TC_CAP_REGION) && (araddr[1:0] == 2'h0);
  assign r_mapped = r_cap || (araddr[7:5] == 3'h0 && araddr[1:0] == 2'h0);
  assign r_capval = cap_value[r_ch];
  assign r_mux    = r_cap ? {24'h0, araddr[2] ? r_capval[7:0] : r_capval[15:8]} :
                    (araddr == `TC_ADDR_PORT_A)     ? {24'h0, port_a_in} :
                    (araddr == `TC_ADDR_PACC)       ? {24'h0, pacc_q} :
                    (araddr == `TC_ADDR_EDGE)       ? {24'h0, edge_q} :
                    (araddr == `TC_ADDR_COUNT)      ? {16'h0, count_q} :
                    (araddr == `TC_ADDR_FLAG)       ? {24'h0, flag_q} :
                    (araddr == `TC_ADDR_ENABLE)     ? {24'h0, enable_q} :
                    (araddr == `TC_ADDR_OC1_MASK)   ? {24'h0, oc1_mask_q} :
                    (araddr == `TC_ADDR_OC_CONNECT) ? {24'h0, connect_q} : 32'h0;
  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // Read answer one cycle after the address; a high-byte read holds off that channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `TC_RESP_OKAY;
      block_q  <= '0;
    end else begin
      block_q <= '0;
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= r_mux;
        rresp_q  <= r_mapped ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
        if (r_cap && !araddr[2]) block_q[r_ch] <= 1'b1;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Checks
  // Sampled reset keeps the release edge, where the count is still being cleared, out of the check
  property p_count_step;
    @(posedge aclk) disable iff (!aresetn) aresetn && count_tick |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_wrap_flag;
    @(posedge aclk) disable iff (!aresetn) wrap |=> count_q == 16'h0000 && flag_q[7];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap lost");

  property p_div4;
    @(posedge aclk) disable iff (!aresetn)
      count_tick && pacc_q.prescale_select == 2'h1 && $stable(pacc_q) |=> !count_tick [*3];
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four broken");

  property p_cap_value;
    @(posedge aclk) disable iff (!aresetn) strobe[0] |=> cap_value[0] == $past(count_q);
  endproperty
  a_cap_value: assert property (p_cap_value) else $error("capture value wrong");

  property p_block;
    @(posedge aclk) disable iff (!aresetn) block_q[1] |-> !strobe[1];
  endproperty
  a_block: assert property (p_block) else $error("capture during block");

  property p_edge_off;
    @(posedge aclk) disable iff (!aresetn) edge_q[1:0] == 2'h0 |-> !strobe[0];
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("disabled channel captured");

  property p_ch4_gate;
    @(posedge aclk) disable iff (!aresetn) !pacc_q.ch4_capture_select |-> !strobe[3];
  endproperty
  a_ch4_gate: assert property (p_ch4_gate) else $error("capture 4 while compare 5");

  property p_owned_pin;
    @(posedge aclk) disable iff (!aresetn) owned[6] |-> port_a_out[6] == compare_level[3];
  endproperty
  a_owned_pin: assert property (p_owned_pin) else $error("owned pin not from compare");

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn) strobe[2] |=> flag_q[2];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("capture flag not set");

  property p_same_value;
    @(posedge aclk) disable iff (!aresetn) strobe[0] && strobe[1] |=> cap_value[0] == cap_value[1];
  endproperty
  a_same_value: assert property (p_same_value) else $error("channels disagree");

  c_capture:  cover property (@(posedge aclk) strobe[0]);
  c_wrap:     cover property (@(posedge aclk) wrap);
  c_delayed:  cover property (@(posedge aclk) block_q[0] ##1 strobe[0]);
  c_ch4:      cover property (@(posedge aclk) strobe[3]);
  c_irq:      cover property (@(posedge aclk) capture_irq);

  // A capture held off by a high-byte read lands on the very next cycle
  property p_block_land;
    @(posedge aclk) disable iff (!aresetn)
      block_q[0] && g_ch[0].u_ch.pending_q && g_ch[0].u_ch.armed |=> strobe[0] || !g_ch[0].u_ch.armed;
  endproperty
  a_block_land: assert property (p_block_land) else $error("held capture lost");

  // Capture mode freezes the shared register against software
  property p_ch4_hold;
    @(posedge aclk) disable iff (!aresetn) pacc_q.ch4_capture_select && !strobe[3] |=> $stable(cap_value[3]);
  endproperty
  a_ch4_hold: assert property (p_ch4_hold) else $error("shared register written in capture mode");

  // The tap pulses once per chain period, never on nearby cycles
  property p_wdog_gap;
    @(posedge aclk) disable iff (!aresetn) watchdog_tick |=> !watchdog_tick [*8];
  endproperty
  a_wdog_gap: assert property (p_wdog_gap) else $error("watchdog tap too frequent");

  // A port write leaves every compare-owned level as it was
  property p_port_keep;
    @(posedge aclk) disable iff (!aresetn)
      aresetn && wr_ok && wa == `TC_ADDR_PORT_A |=>
        (port_out_q & $past(owned)) == ($past(port_out_q) & $past(owned));
  endproperty
  a_port_keep: assert property (p_port_keep) else $error("owned port level overwritten");

  // Direction bit clear and no compare owner: the shared pin stays an input
  property p_shared_in;
    @(posedge aclk) disable iff (!aresetn) !pacc_q.pa3_direction_bit && !owned[3] |-> port_a_oe_n[3];
  endproperty
  a_shared_in: assert property (p_shared_in) else $error("shared pin driven while input");

endmodule : timer_input_capture

// ===== logic/timer_capture_consts.svh
// Register map, field positions, reset values and encodings for the timer capture block
//
// Notes on behaviour
// - Counter rate is bus clock /1, /4, /8, /16
// - Watchdog tick is bus clock over 2^15
// - Counter counts up from zero, wraps, flags overflow
// - Capture pin levels always readable by software
// - Compare-owned pins ignore general-purpose level writes
// - First compare channel may drive pins 7..3
// - Accumulator pin: GPIO, accumulator input, first compare
// - Shared pin: GPIO, capture 4, compare 5, compare 1
// - Selected edge latches counter into capture register
// - Edges synchronised; latch never meets counter increment
// - All sixteen counter bits move in one transfer
// - Reset clears shared pin direction bit: input
// - Reset selects compare 5; set bit enables capture 4
// - Software edges on output shared pin trigger capture
// - Writes to shared register ignored in capture mode
// - Edge code: off, rising, falling, both
// - Four edge pairs, all cleared by reset
// - Channels independent; same period gives same value
// - Capture registers keep contents through reset
// - Capture value read as high and low bytes
// - High-byte read delays a capture one cycle, keeps it
`ifndef TIMER_CAPTURE_CONSTS_SVH
`define TIMER_CAPTURE_CONSTS_SVH

// Byte addresses on the register bus
`define TC_ADDR_PORT_A     8'h00
`define TC_ADDR_PACC       8'h04
`define TC_ADDR_EDGE       8'h08
`define TC_ADDR_COUNT      8'h0C
`define TC_ADDR_FLAG       8'h10
`define TC_ADDR_ENABLE     8'h14
`define TC_ADDR_OC1_MASK   8'h18
`define TC_ADDR_OC_CONNECT 8'h1C
// Capture bytes: addr[7:5] = region, addr[4:3] = channel, addr[2] = low byte
`define TC_CAP_REGION      3'h1

// Reset values and counter maximum
`define TC_COUNT_RESET     16'h0000
`define TC_COUNT_MAX       16'hFFFF
`define TC_BYTE_RESET      8'h00

// Field positions
`define TC_FLAG_OVF        7
`define TC_PIN_SHARED      3

// Edge select codes
`define TC_EDGE_OFF        2'h0
`define TC_EDGE_RISE       2'h1
`define TC_EDGE_FALL       2'h2

// Prescaler masks on the low divider bits, and the divider chain width
`define TC_MASK_DIV1       4'h0
`define TC_MASK_DIV4       4'h3
`define TC_MASK_DIV8       4'h7
`define TC_MASK_DIV16      4'hF
`define TC_WD_CHAIN_W      15

// Bus responses
`define TC_RESP_OKAY       2'h0
`define TC_RESP_SLVERR     2'h2

`endif

// ===== logic/timer_capture_pkg.sv
// Types shared by the timer capture block
package timer_capture_pkg;

  // Pin and prescale control word
  typedef struct packed {
    logic       pa7_dir;
    logic [2:0] spare;
    logic       pa3_direction_bit;
    logic       ch4_capture_select;
    logic [1:0] prescale_select;
  } pacc_t;

  // One-hot write channel states
  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;

endpackage : timer_capture_pkg

// ===== logic/timer_prescaler.sv
// Divider chain: counter tick enable and watchdog tap
`timescale 1ns/1ns
`include "timer_capture_consts.svh"
module timer_prescaler #(
  parameter int CHAIN_W = `TC_WD_CHAIN_W
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Rate select
  input  wire logic [1:0] prescale_select,
  // Enables
  output logic            count_tick,
  output logic            watchdog_tick
);

  logic [CHAIN_W-1:0] chain_q;
  logic [3:0]         mask;

  // Chain runs at the bus clock
  always_ff @(posedge aclk) begin
    if (!aresetn) chain_q <= '0;
    else          chain_q <= chain_q + 1'b1;
  end

  // Rate select picks how many low bits must be all ones
  assign mask = (prescale_select == 2'h0) ? `TC_MASK_DIV1 :
                (prescale_select == 2'h1) ? `TC_MASK_DIV4 :
                (prescale_select == 2'h2) ? `TC_MASK_DIV8 : `TC_MASK_DIV16;
  assign count_tick    = ((chain_q[3:0] & mask) == mask);
  assign watchdog_tick = &chain_q;

endmodule : timer_prescaler

// ===== logic/capture_channel.sv
// One capture channel: edge detect, synchroniser stage and capture latch
`timescale 1ns/1ns
`include "timer_capture_consts.svh"
module capture_channel #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Event input and configuration
  input  wire logic         pin,
  input  wire logic [1:0]   edge_sel,
  input  wire logic         enable,
  input  wire logic         block,
  // Counter and software load
  input  wire logic [W-1:0] count,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  // Results
  output logic [W-1:0]      value_q,
  output logic              strobe
);

  logic prev_q;
  logic pending_q;
  logic hit;
  logic armed;

  // Edge decode on the sampled pin
  assign armed  = enable && (edge_sel != `TC_EDGE_OFF);
  assign hit    = armed && ((edge_sel[0] && pin && !prev_q) ||
                            (edge_sel[1] && !pin && prev_q));
  // A blocked transfer waits; it is dropped only if the channel is disarmed
  assign strobe = pending_q && armed && !block;

  // Pending stage: the edge waits one cycle before the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q    <= 1'b0;
      pending_q <= 1'b0;
    end else begin
      prev_q    <= pin;
      pending_q <= armed && (hit || (pending_q && block));
    end
  end

  // Latch has no reset so captured times survive it
  always_ff @(posedge aclk) begin
    if (strobe)     value_q <= count;
    else if (wr_en) value_q <= wr_data;
  end

endmodule : capture_channel

// ===== verification/pin_event_model.sv
// Far-side event source that drives the port A timer pins
`timescale 1ns/1ns
module pin_event_model (
  // Clock
  input  wire logic       aclk,
  // Levels requested by the bench
  input  wire logic [7:0] level_req,
  // Device pin drive
  input  wire logic [7:0] port_a_out,
  input  wire logic [7:0] port_a_oe_n,
  // Resolved pin levels
  output logic [7:0]      port_a_in
);
  logic [7:0] ext_q;

  // External events land one clock late, as an unsynchronised source would
  always_ff @(posedge aclk) begin
    ext_q <= level_req;
  end

  // A pin that the device drives shows the device level, so its own edges reach capture
  assign port_a_in = (~port_a_oe_n & port_a_out) | (port_a_oe_n & ext_q);
endmodule : pin_event_model

// ===== verification/timer_input_capture_tb.sv
// Self-checking bench for the timer input capture block
`timescale 1ns/1ns
module timer_input_capture_tb;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [7:0]  port_a_in;
  logic [7:0]  port_a_out;
  logic [7:0]  port_a_oe_n;
  logic [4:0]  compare_level;
  logic        watchdog_tick;
  logic        capture_irq;
  logic [7:0]  level_req;
  logic [1:0]  last_bresp;
  logic [1:0]  last_rresp;
  int          ar_cyc;
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;

  timer_input_capture DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .port_a_in, .port_a_out, .port_a_oe_n, .compare_level, .watchdog_tick, .capture_irq);

  pin_event_model u_pins (.aclk, .level_req, .port_a_out, .port_a_oe_n, .port_a_in);

  // Clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Hang guard: the full run needs about 67000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("mismatches=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic pins(input logic [7:0] v);
    level_req <= v;
    @(posedge aclk);
  endtask : pins

  // Register write; handshakes are judged at negedge, the value they hold at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic a_hs;
    logic w_hs;
    logic b_hs;
    b_hs = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      a_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid;
      last_bresp = bresp;
      @(posedge aclk);
      if (a_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar_hs;
    logic r_hs;
    r_hs = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid & arready;
      r_hs = rvalid;
      d = rdata;
      last_rresp = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (ar_hs) ar_cyc = cyc;
      if (r_hs) rready <= 1'b0;
    end
    @(posedge aclk);
  endtask : rd

  // High byte first keeps the pair coherent
  task automatic cap(input int ch, output logic [15:0] v);
    logic [31:0] h;
    logic [31:0] l;
    rd(8'(32 + 8 * ch), h);
    rd(8'(36 + 8 * ch), l);
    v = {h[7:0], l[7:0]};
  endtask : cap

  task automatic t_reset();
    logic [31:0] d;
    chk(port_a_oe_n, 8'h8F);
    rd(8'h04, d);
    chk(d, 32'h00000000);
    rd(8'h08, d);
    chk(d, 32'h00000000);
    rd(8'h10, d);
    chk(d, 32'h00000000);
    rd(8'h80, d);
    chk(last_rresp, 2'h2);
    wr(8'h80, 8'h00);
    chk(last_bresp, 2'h2);
  endtask : t_reset

  // Counter advance over a measured interval for every rate
  task automatic t_prescale();
    int          dv[4] = '{1, 4, 8, 16};
    logic [31:0] c1;
    logic [31:0] c2;
    logic [15:0] dc;
    int          t1;
    int          n;
    for (int p = 0; p < 4; p++) begin
      wr(8'h04, 8'(p));
      rd(8'h0C, c1);
      t1 = ar_cyc;
      tick(40);
      rd(8'h0C, c2);
      n = (ar_cyc - t1) / dv[p];
      dc = c2[15:0] - c1[15:0];
      chk(dc == n || (p > 0 && dc == n + 1), 1'b1);
    end
    wr(8'h04, 8'h00);
  endtask : t_prescale

  // Every edge code on every dedicated channel; other channels stay quiet
  task automatic t_edges();
    logic [31:0] d;
    for (int ch = 0; ch < 3; ch++) begin
      for (int code = 0; code < 4; code++) begin
        wr(8'h14, 8'(1 << ch));
        wr(8'h08, 8'(code << (2 * ch)));
        wr(8'h10, 8'hFF);
        pins(8'(1 << ch));
        tick(4);
        rd(8'h10, d);
        chk(d[3:0], 4'(code % 2) << ch);
        chk(capture_irq, code % 2);
        wr(8'h10, 8'hFF);
        pins(8'h00);
        tick(4);
        rd(8'h10, d);
        chk(d[3:0], 4'(code / 2) << ch);
      end
    end
    wr(8'h14, 8'h00);
  endtask : t_edges

  task automatic t_values();
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    int          s;
    wr(8'h08, 8'h3F);
    s = cyc;
    pins(8'h07);
    tick(4);
    cap(0, a);
    cap(1, b);
    cap(2, c);
    chk(b, a);
    chk(c, a);
    while (cyc < s + 256) @(posedge aclk);
    pins(8'h06);
    tick(4);
    cap(0, b);
    chk(16'(b - a), 16'h0100);
  endtask : t_values

  task automatic t_shared();
    logic [15:0] v;
    logic [31:0] d;
    wr(8'h3C, 8'h5A);
    wr(8'h38, 8'hA5);
    cap(3, v);
    chk(v, 16'hA55A);
    wr(8'h04, 8'h04);
    wr(8'h38, 8'h00);
    wr(8'h3C, 8'h00);
    cap(3, v);
    chk(v, 16'hA55A);
    wr(8'h04, 8'h0C);
    chk(port_a_oe_n[3], 1'b0);
    wr(8'h08, 8'h40);
    wr(8'h10, 8'hFF);
    wr(8'h00, 8'h08);
    tick(4);
    rd(8'h10, d);
    chk(d[3], 1'b1);
  endtask : t_shared

  task automatic t_ports();
    logic [31:0] d;
    wr(8'h08, 8'h03);
    pins(8'h05);
    rd(8'h00, d);
    chk(d[2:0], 3'h5);
    compare_level <= 5'h12;
    wr(8'h1C, 8'h10);
    wr(8'h18, 8'h80);
    wr(8'h00, 8'h00);
    chk(port_a_out[4], 1'b1);
    chk(port_a_out[7], 1'b1);
    chk(port_a_oe_n[7], 1'b0);
  endtask : t_ports

  // A capture that meets a high-byte read must still land
  task automatic t_block();
    logic [31:0] d;
    wr(8'h10, 8'hFF);
    level_req <= 8'h00;
    tick(1);
    rd(8'h20, d);
    tick(4);
    rd(8'h10, d);
    chk(d[0], 1'b1);
  endtask : t_block

  // Capture survives reset; then watchdog period and counter wrap from this reset
  task automatic t_keep_wdog();
    logic [15:0] a;
    logic [15:0] b;
    logic [31:0] d;
    int          s;
    int          t0;
    cap(0, a);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    s = cyc;
    cap(0, b);
    chk(b, a);
    do @(negedge aclk); while (watchdog_tick !== 1'b1);
    t0 = cyc;
    @(negedge aclk);
    do @(negedge aclk); while (watchdog_tick !== 1'b1);
    chk(cyc - t0, 32768);
    @(posedge aclk);
    while (cyc < s + 65600) @(posedge aclk);
    rd(8'h10, d);
    chk(d[7], 1'b1);
    rd(8'h0C, d);
    chk(d[15:8], 8'h00);
  endtask : t_keep_wdog

  // Main sequence
  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    compare_level = 5'h00;
    level_req = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_prescale();
    t_edges();
    t_values();
    t_shared();
    t_ports();
    t_block();
    t_keep_wdog();
    tally_and_finish();
  end
endmodule : timer_input_capture_tb
